// *** design/dcc_channel.sv ***
// Functional notes
// - second channel phase offset top byte, reset zero
// - Q test enable substitutes generator B samples
// - I test enable substitutes generator A samples
// - mixer bit zero means real mixing
// - gain bit doubles samples, else unity
// - IF mode picks variable, zero, fs, test
// - complex-to-real emits I only, extra mix
// - codes 000-010 give ratios 4, 8, 16
// - code 011 gives ratio 2 or 1
// - codes 100-110 give ratios 6, 12, 24
// - code 111 defers to extended field
// - extended code 0 gives ratio 48/24
// - extended 2, 3, 4 give 10, 20, 40
// - NCO adds 48-bit increment each sample in variable IF mode only
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ns
`include "dcc_cfg.svh"
module dcc_channel import dcc_pkg::*; #(
	parameter int W = 16
) (
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic         wb_cyc_i,
	input  wire logic         wb_stb_i,
	input  wire logic         wb_we_i,
	input  wire logic [11:0]  wb_adr_i,
	input  wire logic [31:0]  wb_dat_i,
	input  wire logic [3:0]   wb_sel_i,
	output logic      [31:0]  wb_dat_o,
	output logic              wb_ack_o,
	input  wire logic [W-1:0] ch3_i_in,
	input  wire logic [W-1:0] ch3_q_in,
	input  wire logic         ch3_in_valid,
	output logic              ch3_in_ready,
	output logic      [W-1:0] ch3_out_i,
	output logic      [W-1:0] ch3_out_q,
	output logic              ch3_out_valid,
	input  wire logic         ch3_out_ready,
	input  wire logic [W-1:0] ch2_i_in,
	input  wire logic [W-1:0] ch2_q_in,
	input  wire logic [W-1:0] test_a_in,
	input  wire logic [W-1:0] test_b_in,
	output logic      [W-1:0] ch2_i_out,
	output logic      [W-1:0] ch2_q_out,
	output logic      [7:0]   ch2_phase_offset_top
);
	// the fixed test level assumes sixteen-bit samples; the mixer saturation limits follow W
	if (W != 16) begin : g_bad_w
		$error("dcc_channel: test level needs W of 16");
	end

	// ----------------------------------------
	// register bus
	// ----------------------------------------
	logic [9:0]  idx;
	logic        req, wr;
	logic        i_test_ff, q_test_ff;
	logic [7:0]  ctrl_ff;
	logic [3:0]  ext_ff;
	logic        isel_ff, qsel_ff;
	logic [47:0] inc_ff;
	logic [31:0] nxt_dat;
	dcc_ratio_t  ratio;
	dcc_stages_t stages;

	assign idx = wb_adr_i[11:2];
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr  = req && wb_we_i && wb_sel_i[0];

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= req;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			ch2_phase_offset_top <= `DCC_RST_PHOFF;
		else if (wr && idx == `DCC_IDX_PHOFF_TOP)
			ch2_phase_offset_top <= wb_dat_i[7:0];
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			i_test_ff <= 1'(`DCC_RST_TEST >> `DCC_BIT_TEST_I);
			q_test_ff <= 1'(`DCC_RST_TEST >> `DCC_BIT_TEST_Q);
		end else if (wr && idx == `DCC_IDX_TEST_EN) begin
			i_test_ff <= wb_dat_i[`DCC_BIT_TEST_I];
			q_test_ff <= wb_dat_i[`DCC_BIT_TEST_Q];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			ctrl_ff <= `DCC_RST_CTRL;
		else if (wr && idx == `DCC_IDX_CTRL)
			ctrl_ff <= wb_dat_i[7:0];
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ext_ff  <= 4'(`DCC_RST_SRC >> `DCC_BIT_EXT_LO);
			isel_ff <= 1'(`DCC_RST_SRC >> `DCC_BIT_ISEL);
			qsel_ff <= 1'(`DCC_RST_SRC >> `DCC_BIT_QSEL);
		end else if (wr && idx == `DCC_IDX_SRC) begin
			ext_ff  <= wb_dat_i[`DCC_BIT_EXT_HI:`DCC_BIT_EXT_LO];
			isel_ff <= wb_dat_i[`DCC_BIT_ISEL];
			qsel_ff <= wb_dat_i[`DCC_BIT_QSEL];
		end
	end

	for (genvar g = 0; g < 6; g++) begin : g_inc
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn)
				inc_ff[8*g +: 8] <= 8'(`DCC_RST_INC >> (8 * g));
			else if (wr && idx == `DCC_IDX_INC0 + 10'(g))
				inc_ff[8*g +: 8] <= wb_dat_i[7:0];
		end
	end

	// reserved bits read zero; unmapped indexes answer with zero
	always_comb begin
		nxt_dat = 32'h0000_0000;
		case (idx)
			`DCC_IDX_PHOFF_TOP: nxt_dat[7:0] = ch2_phase_offset_top;
			`DCC_IDX_TEST_EN: begin
				nxt_dat[`DCC_BIT_TEST_I] = i_test_ff;
				nxt_dat[`DCC_BIT_TEST_Q] = q_test_ff;
			end
			`DCC_IDX_CTRL:      nxt_dat[7:0] = ctrl_ff;
			`DCC_IDX_SRC: begin
				nxt_dat[`DCC_BIT_EXT_HI:`DCC_BIT_EXT_LO] = ext_ff;
				nxt_dat[`DCC_BIT_ISEL] = isel_ff;
				nxt_dat[`DCC_BIT_QSEL] = qsel_ff;
			end
			`DCC_IDX_STAGES:    nxt_dat[5:0] = stages;
			`DCC_IDX_RATIO:     nxt_dat[5:0] = ratio;
			default: begin
				if (idx >= `DCC_IDX_INC0 && idx < `DCC_IDX_INC0 + 10'h6)
					nxt_dat[7:0] = inc_ff[8 * 3'(idx - `DCC_IDX_INC0) +: 8];
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			wb_dat_o <= 32'h0000_0000;
		else if (req)
			wb_dat_o <= nxt_dat;
	end

	// ----------------------------------------
	// filter route and decimation ratio
	// ----------------------------------------
	// stage mask bits: fifth, third, hb4, hb3, hb2, hb1
	function automatic logic [11:0] route(input logic [2:0] p, input logic [3:0] e);
		case (p)
			3'h0:    route = {6'h03, 6'h04};
			3'h1:    route = {6'h07, 6'h08};
			3'h2:    route = {6'h0F, 6'h10};
			3'h3:    route = {6'h01, 6'h02};
			3'h4:    route = {6'h11, 6'h06};
			3'h5:    route = {6'h13, 6'h0C};
			3'h6:    route = {6'h17, 6'h18};
			default: begin
				case (e)
					4'h2:    route = {6'h21, 6'h0A};
					4'h3:    route = {6'h23, 6'h14};
					4'h4:    route = {6'h27, 6'h28};
					default: route = {6'h1F, 6'h30};
				endcase
			end
		endcase
	endfunction

	logic [11:0] rt;
	logic        c2r;
	dcc_ifmode_t ifm;

	assign c2r    = ctrl_ff[`DCC_BIT_C2R];
	assign ifm    = dcc_ifmode_t'(ctrl_ff[`DCC_BIT_IFM_HI:`DCC_BIT_IFM_LO]);
	assign rt     = route(ctrl_ff[`DCC_BIT_DEC_HI:0], ext_ff);
	assign stages = rt[11:6];
	assign ratio  = c2r ? (rt[5:0] >> 1) : rt[5:0];

	// ----------------------------------------
	// datapath
	// ----------------------------------------
	logic           accept, push;
	logic [47:0]    phase_ff;
	logic [1:0]     fs4_ff, quad;
	logic [5:0]     cnt_ff;
	dcc_ratio_t     ratio_ff;
	logic [W-1:0]   mix_a, mix_b, m1_i, m1_q, m2_i, m2_q, push_q;

	assign accept = ch3_in_valid && ch3_in_ready;
	assign mix_a  = (ifm == DCC_IF_TEST) ? `DCC_TEST_LEVEL : ch3_i_in;
	always_comb begin
		if (ifm == DCC_IF_TEST)
			mix_b = '0;
		else if (ctrl_ff[`DCC_BIT_MIX])
			mix_b = ch3_q_in;
		else
			mix_b = ch3_i_in;
	end
	// zero IF and fs IF both leave the carrier where it is
	assign quad = (ifm == DCC_IF_VAR) ? phase_ff[47:46] : 2'h0;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			phase_ff <= 48'h0000_0000_0000;
		else if (accept && ifm == DCC_IF_VAR)
			phase_ff <= phase_ff + inc_ff;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			fs4_ff <= 2'h0;
		else if (accept)
			fs4_ff <= fs4_ff + 2'h1;
	end

	dcc_quad_mixer #(.W(W)) u_nco_mix (
		.a    (mix_a),
		.b    (mix_b),
		.quad (quad),
		.gain (ctrl_ff[`DCC_BIT_GAIN]),
		.y_i  (m1_i),
		.y_q  (m1_q)
	);

	dcc_quad_mixer #(.W(W)) u_real_mix (
		.a    (m1_i),
		.b    (m1_q),
		.quad (c2r ? fs4_ff : 2'h0),
		.gain (1'b0),
		.y_i  (m2_i),
		.y_q  (m2_q)
	);

	assign push_q = c2r ? '0 : m2_q;
	assign push   = accept && (cnt_ff >= ratio - 6'h1);

	// a ratio change restarts the phase of the decimator
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_ff   <= 6'h00;
			ratio_ff <= 6'h04;
		end else begin
			ratio_ff <= ratio;
			if (ratio != ratio_ff)
				cnt_ff <= 6'h00;
			else if (push)
				cnt_ff <= 6'h00;
			else if (accept)
				cnt_ff <= cnt_ff + 6'h01;
		end
	end

	// the buffer full flag stalls the input, so a held output loses nothing
	dcc_pair_buffer #(.W(2 * W), .DEPTH(2)) u_buf (
		.clk       (clk),
		.rstn      (rstn),
		.in_valid  (push),
		.in_ready  (ch3_in_ready),
		.in_data   ({m2_i, push_q}),
		.out_valid (ch3_out_valid),
		.out_ready (ch3_out_ready),
		.out_data  ({ch3_out_i, ch3_out_q})
	);

	// ----------------------------------------
	// second channel output test substitution
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ch2_i_out <= '0;
			ch2_q_out <= '0;
		end else begin
			ch2_i_out <= i_test_ff ? test_a_in : ch2_i_in;
			ch2_q_out <= q_test_ff ? test_b_in : ch2_q_in;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	ack_single_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held over two cycles");
	offset_top_write_a: assert property (
		(wr && idx == `DCC_IDX_PHOFF_TOP) |=> ch2_phase_offset_top == $past(wb_dat_i[7:0]))
		else $error("phase offset top byte not written");
	ch2_q_test_a: assert property (
		q_test_ff |=> ch2_q_out == $past(test_b_in))
		else $error("q test data not substituted");
	ch2_i_pass_a: assert property (
		(!i_test_ff && !$past(i_test_ff)) |=> ch2_i_out == $past(ch2_i_in))
		else $error("i normal data not passed");
	real_mix_feed_a: assert property (
		(!ctrl_ff[7] && ifm != DCC_IF_TEST) |-> mix_b == ch3_i_in)
		else $error("real mixer not fed from i");
	test_gain_a: assert property (
		(ifm == DCC_IF_TEST && ctrl_ff[6] && !c2r) |-> m2_i == 16'h7FFF)
		else $error("gain did not double test level");
	real_only_q_a: assert property (
		(push && c2r) |=> (ch3_out_valid && ch3_in_ready) |-> ch3_out_q == '0)
		else $error("q present with real output");
	ratio_hb12_a: assert property (
		(ctrl_ff[2:0] == 3'h0 && !c2r) |-> ratio == 6'h04)
		else $error("code 000 ratio wrong");
	ratio_hb1_a: assert property (
		(ctrl_ff[2:0] == 3'h3 && c2r) |-> ratio == 6'h01)
		else $error("code 011 ratio wrong");
	ratio_third_a: assert property (
		(ctrl_ff[2:0] == 3'h5 && !c2r) |-> ratio == 6'h0C && stages == 6'h13)
		else $error("code 101 route wrong");
	ext_ignored_a: assert property (
		(ctrl_ff[2:0] != 3'h7 && $stable(ctrl_ff)) |-> $stable(ratio))
		else $error("extended field leaked");
	ratio_ext_zero_a: assert property (
		(ctrl_ff[2:0] == 3'h7 && ext_ff == 4'h0 && !c2r) |-> ratio == 6'h30)
		else $error("extended 0 ratio wrong");
	ratio_fifth_a: assert property (
		(ctrl_ff[2:0] == 3'h7 && ext_ff == 4'h4 && c2r) |-> ratio == 6'h14)
		else $error("extended 4 ratio wrong");
	phase_step_a: assert property (
		(accept && ifm == DCC_IF_VAR) |=> phase_ff == $past(phase_ff) + $past(inc_ff))
		else $error("phase did not advance");
	phase_hold_a: assert property (
		(ifm != DCC_IF_VAR) |=> $stable(phase_ff))
		else $error("phase moved outside variable IF");
	dec_restart_a: assert property (
		(push && ratio > 6'h1 && $stable(ratio)) |=> !push)
		else $error("decimator strobed twice");

	full_stall_c: cover property (!ch3_in_ready && ch3_in_valid);
	ratio_48_c: cover property (push && ratio == 6'h30);
	ch2_both_test_c: cover property (i_test_ff && q_test_ff);
	real_out_c: cover property (push && c2r && ctrl_ff[6]);
	nco_rotate_c: cover property (push && ifm == DCC_IF_VAR && quad != 2'h0);
endmodule

// *** design/dcc_cfg.svh ***
`ifndef DCC_CFG_SVH
`define DCC_CFG_SVH
// ----------------------------------------
// register indexes (byte address = 4 * index)
// ----------------------------------------
`define DCC_IDX_PHOFF_TOP 10'h362
`define DCC_IDX_TEST_EN   10'h367
`define DCC_IDX_CTRL      10'h370
`define DCC_IDX_SRC       10'h371
`define DCC_IDX_INC0      10'h378
`define DCC_IDX_STAGES    10'h37E
`define DCC_IDX_RATIO     10'h37F
// ----------------------------------------
// field positions
// ----------------------------------------
`define DCC_BIT_TEST_Q    2
`define DCC_BIT_TEST_I    0
`define DCC_BIT_MIX       7
`define DCC_BIT_GAIN      6
`define DCC_BIT_IFM_HI    5
`define DCC_BIT_IFM_LO    4
`define DCC_BIT_C2R       3
`define DCC_BIT_DEC_HI    2
`define DCC_BIT_EXT_HI    7
`define DCC_BIT_EXT_LO    4
`define DCC_BIT_QSEL      2
`define DCC_BIT_ISEL      0
// ----------------------------------------
// reset values and levels
// ----------------------------------------
`define DCC_RST_PHOFF     8'h00
`define DCC_RST_TEST      8'h00
`define DCC_RST_CTRL      8'h00
`define DCC_RST_SRC       8'h05
`define DCC_RST_INC       48'h0000_0000_0000
`define DCC_TEST_LEVEL    16'h4000
`endif

// *** design/dcc_pkg.sv ***
package dcc_pkg;
	typedef enum logic [1:0] {
		DCC_IF_VAR  = 2'h0,
		DCC_IF_ZERO = 2'h1,
		DCC_IF_FS   = 2'h2,
		DCC_IF_TEST = 2'h3
	} dcc_ifmode_t;
	typedef logic [5:0] dcc_ratio_t;
	typedef logic [5:0] dcc_stages_t;
endpackage

// *** design/dcc_quad_mixer.sv ***
`timescale 1ns/1ns
module dcc_quad_mixer import dcc_pkg::*; #(
	parameter int W = 16
) (
	input  wire logic signed [W-1:0] a,
	input  wire logic signed [W-1:0] b,
	input  wire logic        [1:0]   quad,
	input  wire logic                gain,
	output logic signed      [W-1:0] y_i,
	output logic signed      [W-1:0] y_q
);
	if (W < 4) begin : g_bad_w
		$error("dcc_quad_mixer: W too small");
	end

	logic signed [W+1:0] ai, bi, ri, rq;

	function automatic logic signed [W-1:0] sat(input logic signed [W+1:0] x);
		if (x > $signed({3'h0, {(W-1){1'b1}}}))
			sat = {1'b0, {(W-1){1'b1}}};
		else if (x < $signed({3'h7, {(W-1){1'b0}}}))
			sat = {1'b1, {(W-1){1'b0}}};
		else
			sat = x[W-1:0];
	endfunction

	// rotation by a quarter turn per step, exact except where negating the most negative value saturates, free of multipliers
	always_comb begin
		ai = {{2{a[W-1]}}, a};
		bi = {{2{b[W-1]}}, b};
		case (quad)
			2'h1: begin
				ri = bi;
				rq = -ai;
			end
			2'h2: begin
				ri = -ai;
				rq = -bi;
			end
			2'h3: begin
				ri = -bi;
				rq = ai;
			end
			default: begin
				ri = ai;
				rq = bi;
			end
		endcase
		y_i = sat(gain ? (ri <<< 1) : ri);
		y_q = sat(gain ? (rq <<< 1) : rq);
	end
endmodule

// *** design/dcc_pair_buffer.sv ***
`timescale 1ns/1ns
module dcc_pair_buffer import dcc_pkg::*; #(
	parameter int W     = 32,
	parameter int DEPTH = 2
) (
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int CW = $clog2(DEPTH + 1);
	if (DEPTH < 2 || W < 1) begin : g_bad_size
		$error("dcc_pair_buffer: bad size");
	end

	logic [W-1:0]  mem_ff [DEPTH];
	logic [CW-1:0] cnt_ff, nxt_cnt;
	logic          push, pop;

	assign push     = in_valid && in_ready;
	assign pop      = out_valid && out_ready;
	assign out_data = mem_ff[0];
	assign nxt_cnt  = CW'(cnt_ff + CW'(push) - CW'(pop));

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_ff    <= '0;
			out_valid <= 1'b0;
			in_ready  <= 1'b0;
		end else begin
			cnt_ff    <= nxt_cnt;
			out_valid <= nxt_cnt != '0;
			in_ready  <= nxt_cnt != CW'(DEPTH);
		end
	end

	// shift toward the head so the output word always sits in entry 0
	for (genvar g = 0; g < DEPTH; g++) begin : g_ent
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn)
				mem_ff[g] <= '0;
			else if (pop) begin
				if (push && CW'(g + 1) == cnt_ff)
					mem_ff[g] <= in_data;
				else if (g < DEPTH - 1)
					mem_ff[g] <= mem_ff[(g < DEPTH - 1) ? g + 1 : g];
			end else if (push && CW'(g) == cnt_ff)
				mem_ff[g] <= in_data;
		end
	end
endmodule

// *** verification/dcc_peer.sv ***
`timescale 1ns/1ns
module dcc_peer (
	input  wire logic        clk,
	input  wire logic        in_ready,
	input  wire logic        out_valid,
	input  wire logic [15:0] out_i,
	input  wire logic [15:0] out_q,
	output logic             in_valid,
	output logic      [15:0] i_smp,
	output logic      [15:0] q_smp,
	output logic             out_ready
);
	int          got   = 0;
	int          stall = 0;
	int          seed  = 37534;
	logic [31:0] last  = 32'h0;
	initial begin
		in_valid = 1'b0;
		i_smp = 16'h0000;
		q_smp = 16'h0000;
		out_ready = 1'b0;
	end
	// ----------------------------------------
	// sink: stall 4 never takes, 0 always takes
	// ----------------------------------------
	always @(posedge clk) begin
		out_ready <= (($random(seed) & 3) >= stall);
		if (out_valid && out_ready) begin
			got <= got + 1;
			last <= {out_i, out_q};
		end
	end
	// ----------------------------------------
	// source: hold each sample until accepted
	// ----------------------------------------
	task automatic send(input int n, input logic [15:0] i, input logic [15:0] q);
		int k;
		k = 0;
		@(posedge clk);
		in_valid <= 1'b1;
		i_smp <= i;
		q_smp <= q;
		while (k < n) begin
			@(posedge clk);
			if (in_ready) k++;
		end
		in_valid <= 1'b0;
		// released lines show garbage, not the last sample
		i_smp <= ~i;
		q_smp <= ~q;
	endtask
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/1ns
`include "dcc_cfg.svh"
module tb_top import dcc_pkg::*;;
	logic        clk, rstn, cyc, stb, we, ack, iv, ir, ov, ordy;
	logic [11:0] adr;
	logic [31:0] wdat, rdat;
	logic [3:0]  sel, sv;
	logic [15:0] ii, iq, oi, oq, c2i, c2q, ta, tbv, c2io, c2qo, xi, xq;
	logic [7:0]  r, ofs, pt;
	int          mismatches, tests_run, seed, x, g;
	int          rt[8] = '{4, 8, 16, 2, 6, 12, 24, 48};
	int          xt[5] = '{48, 48, 10, 20, 40};
	int          xs[4] = '{0, 2, 3, 4};
	int          ix[6] = '{'h362, 'h367, 'h370, 'h371, 'h37F, 'h300};
	int          rv[6] = '{0, 0, 0, 5, 4, 0};
	int          sm[7] = '{'h03, 'h07, 'h0F, 'h01, 'h11, 'h13, 'h17};
	int          xm[5] = '{'h1F, 'h1F, 'h21, 'h23, 'h27};

	dcc_channel u_dut (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
		.ch3_i_in(ii), .ch3_q_in(iq), .ch3_in_valid(iv), .ch3_in_ready(ir),
		.ch3_out_i(oi), .ch3_out_q(oq), .ch3_out_valid(ov), .ch3_out_ready(ordy),
		.ch2_i_in(c2i), .ch2_q_in(c2q), .test_a_in(ta), .test_b_in(tbv),
		.ch2_i_out(c2io), .ch2_q_out(c2qo), .ch2_phase_offset_top(pt));
	dcc_peer u_peer (.clk(clk), .in_ready(ir), .out_valid(ov), .out_i(oi), .out_q(oq),
		.in_valid(iv), .i_smp(ii), .q_smp(iq), .out_ready(ordy));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] a, input logic [31:0] e, input string m);
		tests_run++;
		if (a !== e) begin
			mismatches++;
			$display("BAD t=%0t %s got %h exp %h", $time, m, a, e);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {a, 2'b00};
		wdat <= {24'h0, d};
		sel <= sv;
		@(posedge clk);
		while (ack !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		if (ack !== 1'b1) begin
			mismatches++;
			$display("BAD t=%0t no bus answer", $time);
		end
		r = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic waitgot(input int t);
		int n;
		n = 0;
		while (u_peer.got < t && n < 3000) begin
			@(posedge clk);
			n++;
		end
	endtask
	function automatic logic [15:0] gx(input logic [15:0] v);
		logic signed [16:0] s;
		s = {v[15], v};
		s = s <<< 1;
		if (s > 17'sd32767) s = 17'sd32767;
		if (s < -17'sd32768) s = -17'sd32768;
		return s[15:0];
	endfunction
	// negation with saturation, as a quarter or half turn of the mixer gives
	function automatic logic [15:0] gn(input logic [15:0] v);
		logic signed [16:0] s;
		s = -$signed({v[15], v});
		if (s > 17'sd32767) s = 17'sd32767;
		return s[15:0];
	endfunction
	// three decimated words per run; sink stalls at random meanwhile
	task automatic run(input logic [7:0] c, input int n, input logic [31:0] y, input logic [31:0] m);
		wb(1'b1, `DCC_IDX_CTRL, c);
		u_peer.stall <= 1;
		g = u_peer.got;
		u_peer.send(3 * n, xi, xq);
		waitgot(g + 3);
		chk(u_peer.got - g, 3, "strobes");
		chk(u_peer.last & m, y & m, "word");
		$display("stream ctl %h done", c);
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{cyc, stb, we, adr, wdat} = '0;
		{c2i, c2q, ta, tbv} = '0;
		sv = 4'hF;
		sel = 4'hF;
		seed = 37534;
		rstn = 1'b0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		for (int k = 0; k < 6; k++) begin
			wb(1'b0, ix[k][9:0], 8'h00);
			chk(r, rv[k], "reset value");
		end
		wb(1'b1, 10'h300, 8'hFF);
		wb(1'b0, 10'h300, 8'h00);
		chk(r, 0, "unmapped");
		$display("registers done");
		ofs = $random(seed);
		wb(1'b1, `DCC_IDX_PHOFF_TOP, ofs);
		sv = 4'hE;
		wb(1'b1, `DCC_IDX_PHOFF_TOP, ~ofs);
		sv = 4'hF;
		wb(1'b0, `DCC_IDX_PHOFF_TOP, 8'h00);
		chk(r, ofs, "offset top");
		chk(pt, ofs, "offset port");
		$display("offset done");
		for (int en = 0; en < 4; en++) begin
			wb(1'b1, `DCC_IDX_TEST_EN, {5'h1F, en[1], 1'b1, en[0]});
			wb(1'b0, `DCC_IDX_TEST_EN, 8'h00);
			chk(r, {5'h0, en[1], 1'b0, en[0]}, "test enable");
			c2i <= $random(seed);
			c2q <= $random(seed);
			ta <= $random(seed);
			tbv <= $random(seed);
			repeat (3) @(posedge clk);
			chk(c2io, en[0] ? ta : c2i, "ch2 i");
			chk(c2qo, en[1] ? tbv : c2q, "ch2 q");
		end
		$display("ch2 test done");
		for (int h = 0; h < 2; h++) begin
			for (int c = 0; c < 11; c++) begin
				x = (c < 7) ? ($random(seed) & 15) : xs[c - 7];
				wb(1'b1, `DCC_IDX_SRC, {x[3:0], 4'h5});
				wb(1'b1, `DCC_IDX_CTRL, {4'h9, h[0], (c < 7) ? c[2:0] : 3'h7});
				wb(1'b0, `DCC_IDX_RATIO, 8'h00);
				chk(r, (c < 7 ? rt[c] : xt[x]) >> h, "ratio");
				wb(1'b0, `DCC_IDX_STAGES, 8'h00);
				chk(r, (c < 7) ? sm[c] : xm[x], "stages");
			end
		end
		$display("ratio table done");
		xi = $random(seed);
		xq = $random(seed);
		wb(1'b1, `DCC_IDX_SRC, 8'h05);
		run(8'h90, 4, {xi, xq}, '1);
		run(8'hD4, 6, {gx(xi), gx(xq)}, '1);
		run(8'h13, 2, {xi, xi}, '1);
		run(8'hF5, 12, {16'h7FFF, 16'h0}, '1);
		run(8'h9B, 1, 32'h0, 32'h0000FFFF);
		wb(1'b1, `DCC_IDX_SRC, 8'h25);
		run(8'h97, 10, {xi, xq}, '1);
		// quarter turn per sample; phase starts at zero, so sample k sees k mod 4
		wb(1'b1, `DCC_IDX_INC0 + 10'h5, 8'h40);
		wb(1'b0, `DCC_IDX_INC0 + 10'h5, 8'h00);
		chk(r, 8'h40, "increment");
		run(8'h84, 6, {xq, gn(xi)}, '1);
		// phase is left at a half turn; fs IF must not rotate by it
		run(8'hA0, 4, {xi, xq}, '1);
		// buffer: stalled sink must back-pressure, then lose nothing
		wb(1'b1, `DCC_IDX_CTRL, 8'h9B);
		u_peer.stall <= 4;
		@(posedge clk);
		g = u_peer.got;
		fork
			u_peer.send(5, xi, xq);
		join_none
		x = 0;
		while (ir !== 1'b0 && x < 100) begin
			@(posedge clk);
			x++;
		end
		repeat (4) @(posedge clk);
		chk(ir, 0, "full");
		chk(u_peer.got - g, 0, "held");
		u_peer.stall <= 0;
		waitgot(g + 5);
		chk(u_peer.got - g, 5, "drained");
		chk(u_peer.last & 32'h0000FFFF, 0, "real q");
		$display("buffer done");
		complete_run;
	end
	initial begin
		repeat (60000) @(posedge clk);
		mismatches++;
		$display("BAD t=%0t watchdog expired", $time);
		complete_run;
	end
endmodule
